//--- design/status_flags.sv
// Status flag bank: ready, level, balancing and engine-run flags behind Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "status_flags_defines.svh"

module status_flags
  import status_flags_pkg::*;
(
  input wire logic CLK_I, // 200 MHz clock.
  input wire logic RST_N_I, // Asynchronous reset, active low.
  input wire logic CYC_I, // Wishbone cycle.
  input wire logic STB_I, // Wishbone strobe.
  input wire logic WE_I, // Wishbone write enable.
  input wire logic [15:0] ADR_I, // Wishbone byte address.
  input wire logic [3:0] SEL_I, // Wishbone byte selects.
  input wire logic [31:0] DAT_I, // Wishbone write data.
  output logic [31:0] DAT_O, // Wishbone read data.
  output logic ACK_O, // Wishbone acknowledge.
  input wire engine_evt_t EVT_I, // Engine start and done events.
  input wire balance_in_t BAL_I, // Balancing settings and events.
  input wire logic [7:0] PIN_LEVEL_I, // Asynchronous pin levels.
  input wire logic [7:0] PIN_DIGITAL_I, // Pins configured as digital.
  output logic BALANCE_ENABLE_O, // Balancing switches may conduct.
  output logic FILTER_RESTART_O, // Pulse: restart filter checks.
  output logic VOLT_COMPARE_OFF_O // Pulse: switch voltage comparators off.
);

  state_t s_q;
  state_t s_d;
  logic req;
  logic [13:0] idx;
  logic main_rise;
  logic aux_rise;
  logic ot_cond;
  logic pause_cond;
  logic bad;

  // Counts cells, then checks adjacent pairs (only when forbid is set) and runs of three in separate passes over the selection.
  function automatic logic bad_setting(input logic [15:0] c, input logic forbid);
    logic [4:0] n;
    logic b;
    n = 5'h00;
    b = 1'b0;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, c[i]};
    end
    if (n > `MAX_BAL_CELLS) begin
      b = 1'b1;
    end
    for (int i = 0; i < 15; i++) begin
      if (forbid && c[i] && c[i+1]) begin
        b = 1'b1;
      end
    end
    for (int i = 0; i < 14; i++) begin
      if (c[i] && c[i+1] && c[i+2]) begin
        b = 1'b1;
      end
    end
    return b;
  endfunction

  assign req = CYC_I && STB_I && !s_q.ack;
  assign idx = ADR_I[15:2];
  assign main_rise = EVT_I.main_start_bit && !s_q.main_prev;
  assign aux_rise = EVT_I.aux_start_bit && !s_q.aux_prev;
  assign ot_cond = (BAL_I.overtemp_protect_on && BAL_I.therm_over) || BAL_I.die_warn;
  assign pause_cond = ot_cond || s_q.control[`CTL_PAUSE_REQ];
  assign bad = bad_setting(BAL_I.cells, BAL_I.forbid_adjacent);

  always_comb begin
    s_d = s_q;
    // The first stage feeds only the second; metastability never reaches logic.
    s_d.pin_sync1 = PIN_LEVEL_I;
    s_d.pin_sync2 = s_q.pin_sync1;
    s_d.main_prev = EVT_I.main_start_bit;
    s_d.aux_prev = EVT_I.aux_start_bit;
    s_d.inject_prev = s_q.control[`CTL_FILTER_INJ];

    // Protection and self-test ready flags; a done event wins over a start.
    if (EVT_I.temp_start && EVT_I.temp_select == `SEL_ROUND_ROBIN) begin
      s_d.diag[`DG_TEMP_CMP] = 1'b0;
    end
    if (EVT_I.temp_start && EVT_I.temp_select == `SEL_SELF_TEST) begin
      s_d.diag[`DG_TEMP_ST] = 1'b0;
    end
    if (EVT_I.volt_start && EVT_I.volt_select == `SEL_ROUND_ROBIN) begin
      s_d.diag[`DG_VOLT_CMP] = 1'b0;
    end
    if (EVT_I.volt_start && EVT_I.volt_select == `SEL_SELF_TEST) begin
      s_d.diag[`DG_VOLT_ST] = 1'b0;
    end
    if (EVT_I.supply_start) begin
      s_d.diag[`DG_SUPPLY_ST] = 1'b0;
    end
    if (EVT_I.temp_round_done) begin
      s_d.diag[`DG_TEMP_CMP] = 1'b1;
    end
    if (EVT_I.temp_selftest_done) begin
      s_d.diag[`DG_TEMP_ST] = 1'b1;
    end
    if (EVT_I.volt_round_done) begin
      s_d.diag[`DG_VOLT_CMP] = 1'b1;
    end
    if (EVT_I.volt_selftest_done) begin
      s_d.diag[`DG_VOLT_ST] = 1'b1;
    end
    if (EVT_I.supply_done) begin
      s_d.diag[`DG_SUPPLY_ST] = 1'b1;
    end

    // Converter ready flags clear on the rising edge of the start bits.
    if (main_rise) begin
      s_d.conv[`CV_CURRENT] = 1'b0;
      s_d.conv[`CV_MAIN] = 1'b0;
    end
    if (aux_rise) begin
      s_d.conv[`CV_AUX_PIN] = 1'b0;
      s_d.conv[`CV_AUX_CELL] = 1'b0;
      s_d.conv[`CV_AUX_MISC] = 1'b0;
    end
    s_d.conv[`CV_CURRENT] = s_d.conv[`CV_CURRENT] | EVT_I.current_meas_done;
    s_d.conv[`CV_AUX_PIN] = s_d.conv[`CV_AUX_PIN] | EVT_I.aux_pin_done;
    s_d.conv[`CV_AUX_CELL] = s_d.conv[`CV_AUX_CELL] | EVT_I.aux_cell_done;
    s_d.conv[`CV_AUX_MISC] = s_d.conv[`CV_AUX_MISC] | EVT_I.aux_misc_done;
    s_d.conv[`CV_MAIN] = s_d.conv[`CV_MAIN] | EVT_I.main_round_done;

    // Injection pulses one restart on its rising edge; while it is held, the filter ready flag stays clear.
    s_d.filter_restart = s_q.control[`CTL_FILTER_INJ] && !s_q.inject_prev;
    if (main_rise || s_q.control[`CTL_FILTER_INJ]) begin
      s_d.comp[`CP_FILTER] = 1'b0;
    end else if (EVT_I.filter_done) begin
      s_d.comp[`CP_FILTER] = 1'b1;
    end
    if (EVT_I.compare_start) begin
      s_d.comp[4:0] = 5'h00;
    end
    s_d.comp[4:0] = s_d.comp[4:0] | EVT_I.compare_done;

    // Engine running flags.
    s_d.dev[`DV_CURRENT_ON] = EVT_I.current_on;
    s_d.dev[`DV_AUX_ON] = EVT_I.aux_on;
    s_d.dev[`DV_MAIN_ON] = EVT_I.main_on;
    s_d.volt_off = s_q.dev[`DV_VOLT_ON] && !s_q.volt_off &&
                   (EVT_I.volt_selftest_done || EVT_I.volt_selftest_abort);
    if (s_q.volt_off) begin
      s_d.dev[`DV_VOLT_ON] = 1'b0;
    end
    if (EVT_I.volt_start && EVT_I.volt_select == `SEL_SELF_TEST) begin
      s_d.dev[`DV_VOLT_ON] = 1'b1;
    end

    // Balancing control and status.
    if (s_q.bal[`BS_CELL_BALANCE_RUNNING] && ot_cond) begin
      s_d.bal[`BS_OT_SEEN] = 1'b1;
    end
    if (BAL_I.module_done && s_q.bal[`BS_MODULE_BALANCE_RUNNING]) begin
      s_d.bal[`BS_MODULE_BALANCE_RUNNING] = 1'b0;
      s_d.bal[`BS_MODULE_BALANCE_FINISHED] = 1'b1;
    end
    case (s_q.bal_state)
      BAL_IDLE: begin
        s_d.bal_state = BAL_IDLE;
      end
      BAL_RUN: begin
        if (BAL_I.fault) begin
          s_d.bal_state = BAL_IDLE;
          s_d.bal[`BS_ABORT] = 1'b1;
          s_d.bal[`BS_MODULE_BALANCE_RUNNING] = 1'b0;
        end else if (BAL_I.cell_done) begin
          s_d.bal_state = BAL_IDLE;
          s_d.bal[`BS_CELL_BALANCE_FINISHED] = 1'b1;
        end else if (pause_cond) begin
          s_d.bal_state = BAL_PAUSE;
        end
      end
      BAL_PAUSE: begin
        // A fault during pause is ignored; abort arms again once running.
        if (BAL_I.cell_done) begin
          s_d.bal_state = BAL_IDLE;
          s_d.bal[`BS_CELL_BALANCE_FINISHED] = 1'b1;
        end else if (!pause_cond) begin
          s_d.bal_state = BAL_RUN;
        end
      end
      default: begin
        s_d.bal_state = BAL_IDLE;
      end
    endcase
    if (BAL_I.start) begin
      s_d.bal[`BS_BAD] = bad;
      s_d.bal[`BS_OT_SEEN] = 1'b0;
      s_d.bal[`BS_ABORT] = 1'b0;
      s_d.bal[`BS_CELL_BALANCE_FINISHED] = 1'b0;
      s_d.bal[`BS_MODULE_BALANCE_FINISHED] = 1'b0;
      s_d.bal[`BS_MODULE_BALANCE_RUNNING] = !bad && (BAL_I.module_timer != 8'h00);
      s_d.bal_state = (!bad && (BAL_I.cells != 16'h0000)) ? BAL_RUN : BAL_IDLE;
    end
    s_d.bal[`BS_CELL_BALANCE_RUNNING] = (s_d.bal_state != BAL_IDLE);
    s_d.bal[`BS_PAUSED] = (s_d.bal_state == BAL_PAUSE);
    s_d.balance_drive = (s_d.bal_state == BAL_RUN);

    // Bus slave: one wait state, ack for one cycle, unmapped reads give zero.
    s_d.ack = req;
    s_d.dat = 32'h0000_0000;
    if (req && WE_I && SEL_I[0] && idx == `IDX_CONTROL) begin
      s_d.control = DAT_I[1:0];
    end
    if (req && !WE_I) begin
      case (idx)
        `IDX_DIAG_READY: s_d.dat = {24'h000000, s_q.diag};
        `IDX_CONV_READY: s_d.dat = {24'h000000, s_q.conv};
        `IDX_COMP_READY: s_d.dat = {24'h000000, s_q.comp};
        `IDX_PIN_LEVEL: s_d.dat = {24'h000000, s_q.pin_sync2 & PIN_DIGITAL_I};
        `IDX_BALANCING: s_d.dat = {24'h000000, s_q.bal};
        `IDX_ENGINE_RUN: s_d.dat = {24'h000000, s_q.dev};
        `IDX_CONTROL: s_d.dat = {30'h00000000, s_q.control};
        default: s_d.dat = 32'h0000_0000;
      endcase
    end
    if (req && !WE_I && idx == `IDX_ENGINE_RUN) begin
      s_d.dev[`DV_FACT_CRC] = 1'b0;
      s_d.dev[`DV_USER_CRC] = 1'b0;
    end
    // Completion arriving with the clearing read is kept.
    s_d.dev[`DV_FACT_CRC] = s_d.dev[`DV_FACT_CRC] | EVT_I.factory_checksum_finished;
    s_d.dev[`DV_USER_CRC] = s_d.dev[`DV_USER_CRC] | EVT_I.user_crc_done;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_q.pin_sync1 <= `STATUS_RESET;
      s_q.pin_sync2 <= `STATUS_RESET;
      s_q.diag <= `STATUS_RESET;
      s_q.conv <= `STATUS_RESET;
      s_q.comp <= `STATUS_RESET;
      s_q.bal <= `STATUS_RESET;
      s_q.dev <= `STATUS_RESET;
      s_q.control <= `CONTROL_RESET;
      s_q.bal_state <= BAL_IDLE;
      s_q.balance_drive <= 1'b0;
      s_q.main_prev <= 1'b0;
      s_q.aux_prev <= 1'b0;
      s_q.inject_prev <= 1'b0;
      s_q.filter_restart <= 1'b0;
      s_q.volt_off <= 1'b0;
      s_q.ack <= 1'b0;
      s_q.dat <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign DAT_O = s_q.dat;
  assign ACK_O = s_q.ack;
  assign BALANCE_ENABLE_O = s_q.balance_drive;
  assign FILTER_RESTART_O = s_q.filter_restart;
  assign VOLT_COMPARE_OFF_O = s_q.volt_off;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  property p_temp_ready;
    EVT_I.temp_start && EVT_I.temp_select == `SEL_ROUND_ROBIN && !EVT_I.temp_round_done
      |=> !s_q.diag[`DG_TEMP_CMP];
  endproperty
  a_temp_ready: assert property (p_temp_ready) else $error("temp ready not cleared");

  property p_supply_ready;
    EVT_I.supply_done |=> s_q.diag[`DG_SUPPLY_ST];
  endproperty
  a_supply_ready: assert property (p_supply_ready) else $error("supply ready not set");

  property p_main_ready;
    main_rise && !EVT_I.main_round_done |=> !s_q.conv[`CV_MAIN];
  endproperty
  a_main_ready: assert property (p_main_ready) else $error("main ready not cleared");

  property p_filter_inject;
    s_q.control[`CTL_FILTER_INJ] |=> !s_q.comp[`CP_FILTER];
  endproperty
  a_filter_inject: assert property (p_filter_inject) else $error("filter ready survived");

  property p_compare;
    EVT_I.compare_start && EVT_I.compare_done == 5'h00 |=> s_q.comp[4:0] == 5'h00;
  endproperty
  a_compare: assert property (p_compare) else $error("compare ready not cleared");

  property p_bad_blocks;
    BAL_I.start && bad |=> s_q.bal[`BS_BAD] && !s_q.bal[`BS_CELL_BALANCE_RUNNING] && !BALANCE_ENABLE_O;
  endproperty
  a_bad_blocks: assert property (p_bad_blocks) else $error("invalid setting started");

  property p_paused_runs;
    s_q.bal[`BS_PAUSED] |-> s_q.bal[`BS_CELL_BALANCE_RUNNING] && !BALANCE_ENABLE_O;
  endproperty
  a_paused_runs: assert property (p_paused_runs) else $error("pause without running");

  property p_abort;
    s_q.bal_state == BAL_RUN && BAL_I.fault && !BAL_I.start
      |=> s_q.bal[`BS_ABORT] && !s_q.bal[`BS_CELL_BALANCE_RUNNING];
  endproperty
  a_abort: assert property (p_abort) else $error("fault did not abort");

  property p_no_abort_paused;
    s_q.bal_state == BAL_PAUSE && !BAL_I.start |=> $stable(s_q.bal[`BS_ABORT]);
  endproperty
  a_no_abort_paused: assert property (p_no_abort_paused) else $error("abort in pause");

  sequence s_volt_end;
    s_q.dev[`DV_VOLT_ON] && !s_q.volt_off && !EVT_I.volt_start &&
      (EVT_I.volt_selftest_done || EVT_I.volt_selftest_abort);
  endsequence
  sequence s_switch_off;
    VOLT_COMPARE_OFF_O ##1 !s_q.dev[`DV_VOLT_ON] || s_q.volt_off;
  endsequence
  property p_volt_off;
    s_volt_end ##1 !EVT_I.volt_start |-> s_switch_off;
  endproperty
  a_volt_off: assert property (p_volt_off) else $error("comparators not switched off");

  property p_crc_read;
    req && !WE_I && idx == `IDX_ENGINE_RUN && !EVT_I.user_crc_done
      |=> !s_q.dev[`DV_USER_CRC] && ACK_O;
  endproperty
  a_crc_read: assert property (p_crc_read) else $error("checksum flag not cleared");

  property p_volt_ready;
    EVT_I.volt_start && EVT_I.volt_select == `SEL_SELF_TEST && !EVT_I.volt_selftest_done
      |=> !s_q.diag[`DG_VOLT_ST];
  endproperty
  a_volt_ready: assert property (p_volt_ready) else $error("volt ready not cleared");

  property p_current_ready;
    EVT_I.current_meas_done |=> s_q.conv[`CV_CURRENT];
  endproperty
  a_current_ready: assert property (p_current_ready) else $error("current ready not set");

  property p_aux_pin;
    aux_rise && !EVT_I.aux_pin_done |=> !s_q.conv[`CV_AUX_PIN];
  endproperty
  a_aux_pin: assert property (p_aux_pin) else $error("aux pin ready not cleared");

  property p_misc_ready;
    EVT_I.aux_misc_done |=> s_q.conv[`CV_AUX_MISC];
  endproperty
  a_misc_ready: assert property (p_misc_ready) else $error("aux misc ready not set");

  property p_overtemp_seen;
    s_q.bal[`BS_CELL_BALANCE_RUNNING] && ot_cond && !BAL_I.start |=> s_q.bal[`BS_OT_SEEN];
  endproperty
  a_overtemp_seen: assert property (p_overtemp_seen) else $error("overtemp not seen");

  property p_module_done;
    s_q.bal[`BS_MODULE_BALANCE_RUNNING] && BAL_I.module_done && !BAL_I.start
      |=> s_q.bal[`BS_MODULE_BALANCE_FINISHED] && !s_q.bal[`BS_MODULE_BALANCE_RUNNING];
  endproperty
  a_module_done: assert property (p_module_done) else $error("module done not set");

  property p_ack_pulse;
    ACK_O |=> !ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

endmodule // status_flags
`default_nettype wire

//--- design/status_flags_defines.svh
// Offsets, bit positions, reset values and codes for the status flag bank.
`ifndef STATUS_FLAGS_DEFINES_SVH
`define STATUS_FLAGS_DEFINES_SVH
`define IDX_DIAG_READY 14'h0526
`define IDX_CONV_READY 14'h0527
`define IDX_COMP_READY 14'h0528
`define IDX_PIN_LEVEL 14'h052A
`define IDX_BALANCING 14'h052B
`define IDX_ENGINE_RUN 14'h052C
`define IDX_CONTROL 14'h052D
`define STATUS_RESET 8'h00
`define CONTROL_RESET 2'h0
`define CTL_PAUSE_REQ 0
`define CTL_FILTER_INJ 1
`define SEL_ROUND_ROBIN 2'h1
`define SEL_SELF_TEST 2'h2
`define MAX_BAL_CELLS 5'h08
`define DG_TEMP_CMP 4
`define DG_VOLT_CMP 3
`define DG_TEMP_ST 2
`define DG_VOLT_ST 1
`define DG_SUPPLY_ST 0
`define CV_CURRENT 4
`define CV_AUX_PIN 3
`define CV_AUX_CELL 2
`define CV_AUX_MISC 1
`define CV_MAIN 0
`define CP_FILTER 5
`define BS_BAD 7
`define BS_OT_SEEN 6
`define BS_PAUSED 5
`define BS_MODULE_BALANCE_RUNNING 4
`define BS_CELL_BALANCE_RUNNING 3
`define BS_ABORT 2
`define BS_MODULE_BALANCE_FINISHED 1
`define BS_CELL_BALANCE_FINISHED 0
`define DV_FACT_CRC 6
`define DV_USER_CRC 5
`define DV_VOLT_ON 3
`define DV_CURRENT_ON 2
`define DV_AUX_ON 1
`define DV_MAIN_ON 0
`endif

//--- design/status_flags_pkg.sv
// Types shared by the status flag bank and its users.
package status_flags_pkg;
  typedef enum logic [2:0] {
    BAL_IDLE = 3'b001,
    BAL_RUN = 3'b010,
    BAL_PAUSE = 3'b100
  } bal_state_t;
  typedef struct packed {
    logic temp_start;
    logic [1:0] temp_select;
    logic temp_round_done;
    logic temp_selftest_done;
    logic volt_start;
    logic [1:0] volt_select;
    logic volt_round_done;
    logic volt_selftest_done;
    logic volt_selftest_abort;
    logic supply_start;
    logic supply_done;
    logic main_start_bit;
    logic current_meas_done;
    logic aux_start_bit;
    logic aux_pin_done;
    logic aux_cell_done;
    logic aux_misc_done;
    logic main_round_done;
    logic filter_done;
    logic compare_start;
    logic [4:0] compare_done;
    logic factory_checksum_finished;
    logic user_crc_done;
    logic current_on;
    logic aux_on;
    logic main_on;
  } engine_evt_t;
  typedef struct packed {
    logic start;
    logic [15:0] cells;
    logic forbid_adjacent;
    logic overtemp_protect_on;
    logic therm_over;
    logic die_warn;
    logic [7:0] module_timer;
    logic cell_done;
    logic module_done;
    logic fault;
  } balance_in_t;
  typedef struct packed {
    logic [7:0] pin_sync1;
    logic [7:0] pin_sync2;
    logic [7:0] diag;
    logic [7:0] conv;
    logic [7:0] comp;
    logic [7:0] bal;
    logic [7:0] dev;
    logic [1:0] control;
    bal_state_t bal_state;
    logic balance_drive;
    logic main_prev;
    logic aux_prev;
    logic inject_prev;
    logic filter_restart;
    logic volt_off;
    logic ack;
    logic [31:0] dat;
  } state_t;
endpackage

//--- tb/status_flags_tb_top.sv
// Self-checking testbench for the status flag bank.
`timescale 1ns/1ps
`default_nettype none
`include "status_flags_defines.svh"

module status_flags_tb_top
  import status_flags_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  engine_evt_t evt = '0;
  balance_in_t bal = '0;
  logic [7:0] pin_level = 8'h00;
  logic [7:0] pin_digital = 8'h00;
  logic bal_en;
  logic filt_rst;
  logic volt_off;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_off = 0;
  int n_restart = 0;

  always #2.5 clk = ~clk;

  status_flags status_flags_i (
    .CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .EVT_I(evt), .BAL_I(bal),
    .PIN_LEVEL_I(pin_level), .PIN_DIGITAL_I(pin_digital), .BALANCE_ENABLE_O(bal_en),
    .FILTER_RESTART_O(filt_rst), .VOLT_COMPARE_OFF_O(volt_off)
  );

  // Pulses are counted rather than caught at one edge, so a late pulse still shows.
  always @(posedge clk) begin
    if (volt_off === 1'b1) n_off++;
    if (filt_rst === 1'b1) n_restart++;
  end

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %b seen %b", name, exp, got);
    end
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [13:0] idx, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= wd;
    sel <= 4'hF;
    // Only the watchdog ends a wait that never sees ack.
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [13:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, idx, 32'h0, d);
    chk(name, exp, d);
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    wb(1'b1, idx, wd, d);
  endtask

  // Mode selects take the value of each fired mask, start or not; the other fields in the mask pulse.
  task automatic fire(input engine_evt_t m);
    engine_evt_t e;
    @(posedge clk);
    e = evt | m;
    e.temp_select = m.temp_select;
    e.volt_select = m.volt_select;
    evt <= e;
    @(posedge clk);
    e = e & ~m;
    e.temp_select = m.temp_select;
    e.volt_select = m.volt_select;
    evt <= e;
  endtask

  task automatic bfire(input balance_in_t m);
    @(posedge clk);
    bal <= bal | m;
    @(posedge clk);
    bal <= bal & ~m;
  endtask

  task automatic t_reset;
    logic [31:0] d;
    chk_bit("enable in reset", 1'b0, bal_en);
    rd_chk("diag reset", `IDX_DIAG_READY, 32'h00);
    rd_chk("conv reset", `IDX_CONV_READY, 32'h00);
    rd_chk("comp reset", `IDX_COMP_READY, 32'h00);
    rd_chk("pin reset", `IDX_PIN_LEVEL, 32'h00);
    rd_chk("bal reset", `IDX_BALANCING, 32'h00);
    rd_chk("dev reset", `IDX_ENGINE_RUN, 32'h00);
    rd_chk("control reset", `IDX_CONTROL, 32'h00);
    wr(`IDX_DIAG_READY, 32'hFF);
    rd_chk("diag read only", `IDX_DIAG_READY, 32'h00);
    wb(1'b0, 14'h0600, 32'h0, d);
    chk("unmapped", 32'h00, d);
  endtask

  task automatic t_diag;
    fire(engine_evt_t'{temp_start: 1'b1, temp_select: `SEL_ROUND_ROBIN, default: '0});
    fire(engine_evt_t'{temp_round_done: 1'b1, default: '0});
    rd_chk("temp compare ready", `IDX_DIAG_READY, 32'h10);
    fire(engine_evt_t'{temp_start: 1'b1, temp_select: `SEL_SELF_TEST, default: '0});
    fire(engine_evt_t'{temp_selftest_done: 1'b1, default: '0});
    fire(engine_evt_t'{volt_start: 1'b1, volt_select: `SEL_ROUND_ROBIN, default: '0});
    fire(engine_evt_t'{volt_round_done: 1'b1, default: '0});
    fire(engine_evt_t'{supply_start: 1'b1, default: '0});
    fire(engine_evt_t'{supply_done: 1'b1, default: '0});
    rd_chk("diag after rounds", `IDX_DIAG_READY, 32'h1D);
    fire(engine_evt_t'{volt_start: 1'b1, volt_select: `SEL_SELF_TEST, default: '0});
    rd_chk("volt on", `IDX_ENGINE_RUN, 32'h08);
    fire(engine_evt_t'{volt_selftest_done: 1'b1, default: '0});
    repeat (2) @(posedge clk);
    chk("volt off pulses", 32'd1, 32'(n_off));
    rd_chk("volt self-test ready", `IDX_DIAG_READY, 32'h1F);
    rd_chk("volt on cleared", `IDX_ENGINE_RUN, 32'h00);
    fire(engine_evt_t'{temp_start: 1'b1, temp_select: `SEL_ROUND_ROBIN, default: '0});
    fire(engine_evt_t'{volt_start: 1'b1, volt_select: `SEL_SELF_TEST, default: '0});
    fire(engine_evt_t'{supply_start: 1'b1, default: '0});
    rd_chk("diag cleared by starts", `IDX_DIAG_READY, 32'h0C);
    fire(engine_evt_t'{volt_selftest_abort: 1'b1, default: '0});
    repeat (2) @(posedge clk);
    chk("volt off on abort", 32'd2, 32'(n_off));
    rd_chk("volt on after abort", `IDX_ENGINE_RUN, 32'h00);
  endtask

  task automatic t_conv;
    fire(engine_evt_t'{current_meas_done: 1'b1, aux_pin_done: 1'b1, aux_cell_done: 1'b1,
                       aux_misc_done: 1'b1, main_round_done: 1'b1, filter_done: 1'b1,
                       default: '0});
    rd_chk("conv all ready", `IDX_CONV_READY, 32'h1F);
    rd_chk("filter ready", `IDX_COMP_READY, 32'h20);
    @(posedge clk);
    evt.main_start_bit <= 1'b1;
    rd_chk("conv after main start", `IDX_CONV_READY, 32'h0E);
    rd_chk("filter after main start", `IDX_COMP_READY, 32'h00);
    @(posedge clk);
    evt.main_start_bit <= 1'b0;
    evt.aux_start_bit <= 1'b1;
    rd_chk("conv after aux start", `IDX_CONV_READY, 32'h00);
    @(posedge clk);
    evt.aux_start_bit <= 1'b0;
    fire(engine_evt_t'{compare_done: 5'h1F, default: '0});
    rd_chk("comparisons ready", `IDX_COMP_READY, 32'h1F);
    fire(engine_evt_t'{compare_start: 1'b1, default: '0});
    rd_chk("comparisons cleared", `IDX_COMP_READY, 32'h00);
    fire(engine_evt_t'{filter_done: 1'b1, default: '0});
    wr(`IDX_CONTROL, 32'h2);
    rd_chk("filter on inject", `IDX_COMP_READY, 32'h00);
    chk("filter restarts", 32'd1, 32'(n_restart));
    fire(engine_evt_t'{filter_done: 1'b1, default: '0});
    rd_chk("filter held by inject", `IDX_COMP_READY, 32'h00);
    wr(`IDX_CONTROL, 32'h0);
    fire(engine_evt_t'{filter_done: 1'b1, default: '0});
    rd_chk("filter after inject", `IDX_COMP_READY, 32'h20);
  endtask

  task automatic t_pins_dev;
    @(posedge clk);
    pin_level <= 8'hA5;
    pin_digital <= 8'h0F;
    evt.current_on <= 1'b1;
    evt.aux_on <= 1'b1;
    evt.main_on <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("pins masked", `IDX_PIN_LEVEL, 32'h05);
    @(posedge clk);
    pin_digital <= 8'hFF;
    rd_chk("pins all", `IDX_PIN_LEVEL, 32'hA5);
    fire(engine_evt_t'{factory_checksum_finished: 1'b1, user_crc_done: 1'b1, default: '0});
    rd_chk("engines and checksums", `IDX_ENGINE_RUN, 32'h67);
    rd_chk("checksums cleared by read", `IDX_ENGINE_RUN, 32'h07);
    @(posedge clk);
    evt.aux_on <= 1'b0;
    rd_chk("aux off", `IDX_ENGINE_RUN, 32'h05);
  endtask

  task automatic t_bad_setting;
    logic [15:0] cl [6] = '{16'h2DB6, 16'h0007, 16'h0003, 16'h0DB6, 16'h5555, 16'h0001};
    logic fb [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic ok [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      bal.cells <= cl[i];
      bal.forbid_adjacent <= fb[i];
      bfire(balance_in_t'{start: 1'b1, default: '0});
      rd_chk("start result", `IDX_BALANCING, ok[i] ? 32'h08 : 32'h80);
      chk_bit("enable after start", ok[i], bal_en);
      if (ok[i]) begin
        bfire(balance_in_t'{cell_done: 1'b1, default: '0});
        rd_chk("cell done", `IDX_BALANCING, 32'h01);
      end
    end
  endtask

  task automatic t_pause_abort;
    @(posedge clk);
    bal.module_timer <= 8'h05;
    bfire(balance_in_t'{start: 1'b1, default: '0});
    rd_chk("cell and module run", `IDX_BALANCING, 32'h18);
    wr(`IDX_CONTROL, 32'h1);
    rd_chk("host pause", `IDX_BALANCING, 32'h38);
    chk_bit("enable paused", 1'b0, bal_en);
    bfire(balance_in_t'{fault: 1'b1, default: '0});
    rd_chk("fault while paused", `IDX_BALANCING, 32'h38);
    wr(`IDX_CONTROL, 32'h0);
    rd_chk("resumed", `IDX_BALANCING, 32'h18);
    bfire(balance_in_t'{fault: 1'b1, default: '0});
    rd_chk("aborted", `IDX_BALANCING, 32'h04);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      bal.overtemp_protect_on <= 1'b1;
      bfire(balance_in_t'{start: 1'b1, default: '0});
      rd_chk("start clears abort", `IDX_BALANCING, 32'h18);
      @(posedge clk);
      bal.therm_over <= (k == 0);
      bal.die_warn <= (k == 1);
      rd_chk("overtemp pause", `IDX_BALANCING, 32'h78);
      @(posedge clk);
      bal.therm_over <= 1'b0;
      bal.die_warn <= 1'b0;
    end
    bfire(balance_in_t'{start: 1'b1, default: '0});
    bfire(balance_in_t'{cell_done: 1'b1, module_done: 1'b1, default: '0});
    rd_chk("both done", `IDX_BALANCING, 32'h03);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("FAIL watchdog expected end seen hang");
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_diag();
    t_conv();
    t_pins_dev();
    t_bad_setting();
    t_pause_abort();
    end_of_test();
  end
endmodule // status_flags_tb_top
`default_nettype wire
